// ### sram_ctl_pkg.sv
// Shared constants and types for the synchronous burst SRAM control block
package sram_ctl_pkg;
   localparam int ADDR_W_DEF = 18;   // Word address width
   localparam int LANES_WIDE = 8;    // Lanes on the widest configuration
   localparam int LANES_NARROW = 4;  // Lanes on narrower configurations
   localparam int LANE_W = 9;        // Bits per byte lane, parity included
   localparam int BURST_W = 2;       // Burst counter width
   localparam logic [1:0] BURST_RST = 2'h0;
   localparam logic [1:0] BURST_STEP = 2'h1;
   localparam logic RD_PIPE_RST = 1'h0;
   localparam logic DRIVE_OFF_N = 1'h1;  // Output enable value while not driving

   // Command captured at a clock edge
   typedef enum logic [2:0] {
      CMD_NOP      = 3'b000,
      CMD_DESEL    = 3'b001,
      CMD_RD_BEGIN = 3'b010,
      CMD_WR_BEGIN = 3'b011,
      CMD_RD_CONT  = 3'b100,
      CMD_WR_CONT  = 3'b101,
      CMD_RD_HOLD  = 3'b110,
      CMD_WR_HOLD  = 3'b111
   } cmd_t;
endpackage : sram_ctl_pkg

// ### burst_if.sv
// Burst counter control and address between controller and counter
`timescale 1ns/1ps
`default_nettype none
interface burst_if;
   logic       load;
   logic       advance;
   logic [1:0] start_lo;
   logic       interleave;
   logic [1:0] addr_lo;
   modport ctl (output load, output advance, output start_lo, output interleave,
                input addr_lo);
   modport cnt (input load, input advance, input start_lo, input interleave,
                output addr_lo);
endinterface : burst_if
`default_nettype wire

// ### burst_counter.sv
// Two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control from the command decoder
   burst_if.cnt      bus
);
   import sram_ctl_pkg::*;

   typedef struct packed {
      logic [1:0] start;
      logic [1:0] step;
   } cnt_state_t;

   cnt_state_t st_r;
   cnt_state_t st_nxt;

   // Load, step or hold; two-bit step wraps to the loaded value
   always_comb begin
      st_nxt = st_r;
      if (bus.load) begin
         st_nxt.start = bus.start_lo;
         st_nxt.step  = BURST_RST;
      end else if (bus.advance) begin
         st_nxt.step = st_nxt.step + BURST_STEP;
      end
   end

   // Address of the cycle being captured now
   always_comb begin
      if (bus.interleave) begin
         bus.addr_lo = st_nxt.start ^ st_nxt.step;
      end else begin
         bus.addr_lo = st_nxt.start + st_nxt.step;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '{start: BURST_RST, step: BURST_RST};
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : burst_counter
`default_nettype wire

// ### lane_memory.sv
// Word memory with per-lane write enables and registered read data
`timescale 1ns/1ps
`default_nettype none
module lane_memory #(
   parameter int ADDR_W = 18,
   parameter int LANES  = 8,
   parameter int LANE_W = 9
) (
   // Clock
   input  wire logic                      clk_i,
   // Access port
   input  wire logic [ADDR_W-1:0]         addr_i,
   input  wire logic [LANES-1:0]          lane_we_i,
   input  wire logic [LANES*LANE_W-1:0]   wdata_i,
   output logic      [LANES*LANE_W-1:0]   rdata_o
);
   // Sizes the array cannot serve
   if (ADDR_W < 1 || LANES < 1 || LANE_W < 1) begin : g_bad_size
      $error("lane_memory size out of range");
   end

   // One array per lane, so each has a single writing process
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

      // Lane write and registered read of the addressed word
      always_ff @(posedge clk_i) begin
         if (lane_we_i[l]) begin
            mem[addr_i] <= wdata_i[l*LANE_W +: LANE_W];
         end
         rdata_o[l*LANE_W +: LANE_W] <= mem[addr_i];
      end
   end
endmodule : lane_memory
`default_nettype wire

// ### sync_burst_sram_control.sv
// Synchronous burst SRAM control: command decode, burst, write lanes, output drive
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_control #(
   parameter int ADDR_W = sram_ctl_pkg::ADDR_W_DEF,
   parameter int LANES  = sram_ctl_pkg::LANES_WIDE
) (
   // Clock and reset
   input  wire logic                                   MCLK_I,
   input  wire logic                                   RST_I,
   // Mode pins
   input  wire logic                                   BURST_ORDER_SEL_N_I,
   input  wire logic                                   OUTPUT_STAGE_BYPASS_N_I,
   input  wire logic                                   DESELECT_DEPTH_SEL_I,
   input  wire logic                                   SLEEP_REQ_I,
   // Chip selects
   input  wire logic                                   CHIP_SEL_PRIMARY_N_I,
   input  wire logic                                   CHIP_SEL_POS_I,
   input  wire logic                                   CHIP_SEL_AUX_N_I,
   // Address and burst control
   input  wire logic [ADDR_W-1:0]                      ADDR_I,
   input  wire logic                                   PROC_ADDR_STROBE_N_I,
   input  wire logic                                   CTRL_ADDR_STROBE_N_I,
   input  wire logic                                   BURST_ADVANCE_N_I,
   // Write control, lane 0 is A
   input  wire logic                                   ALL_LANES_WRITE_N_I,
   input  wire logic                                   LANE_WRITE_GATE_N_I,
   input  wire logic [LANES-1:0]                       LANE_WE_N_I,
   // Output enable
   input  wire logic                                   OUT_EN_N_I,
   // Data pins
   input  wire logic [LANES*sram_ctl_pkg::LANE_W-1:0]  DQ_I,
   output logic      [LANES*sram_ctl_pkg::LANE_W-1:0]  DQ_O,
   output logic                                        DQ_OE_N_O,
   // Status
   output logic                                        STANDBY_O,
   output sram_ctl_pkg::cmd_t                          LAST_CMD_O
);
   import sram_ctl_pkg::*;

   localparam int DATA_W = LANES * LANE_W;
   localparam int HI_W   = ADDR_W - BURST_W;

   // Lane count is the wide or narrow configuration only
   if (LANES != LANES_WIDE && LANES != LANES_NARROW) begin : g_bad_lanes
      $error("LANES must be 4 or 8");
   end
   if (ADDR_W <= BURST_W || ADDR_W > 24) begin : g_bad_addr
      $error("ADDR_W out of range");
   end

   typedef struct packed {
      logic [HI_W-1:0]   base_hi;  // Upper address of the open burst
      cmd_t              cmd;      // Command captured at the last edge
      logic              rd_s1;    // Read captured at the last edge
      logic              rd_s2;    // Read captured one edge earlier
      logic              wr_s1;    // Write captured at the last edge
      logic              desel_s1; // Deselect captured at the last edge
      logic [DATA_W-1:0] pipe;     // Output register of pipelined mode
      logic [DATA_W-1:0] dq;       // Data on the pins
      logic              oe_n;     // Pin driver enable, low drives
      logic              standby;  // Sleep state
   } ctl_state_t;

   ctl_state_t st_r;
   ctl_state_t st_nxt;

   burst_if bif ();

   logic              selected;
   logic              wr_cond;
   logic [LANES-1:0]  lanes_wr;
   logic              sleeping;
   cmd_t              cmd_now;
   logic              is_read;
   logic              is_write;
   logic [HI_W-1:0]   hi_now;
   logic [ADDR_W-1:0] mem_addr;
   logic [LANES-1:0]  mem_we;
   logic [DATA_W-1:0] mem_rdata;
   logic              pipelined;
   logic              single_desel;
   logic              src_read;
   logic [DATA_W-1:0] src_data;

   // Mode pins
   assign pipelined    = OUTPUT_STAGE_BYPASS_N_I;
   assign single_desel = DESELECT_DEPTH_SEL_I;
   assign sleeping     = SLEEP_REQ_I;

   // Chip select and write decode
   assign selected = !CHIP_SEL_PRIMARY_N_I && CHIP_SEL_POS_I && !CHIP_SEL_AUX_N_I;
   always_comb begin
      if (!ALL_LANES_WRITE_N_I) begin
         lanes_wr = '1;
      end else if (!LANE_WRITE_GATE_N_I) begin
         lanes_wr = ~LANE_WE_N_I;
      end else begin
         lanes_wr = '0;
      end
   end
   assign wr_cond = |lanes_wr;

   // Command decode from the active-low strobes
   always_comb begin
      if (sleeping) begin
         cmd_now = CMD_NOP;
      end else if (!selected && !CTRL_ADDR_STROBE_N_I) begin
         cmd_now = CMD_DESEL;
      end else if (selected && !PROC_ADDR_STROBE_N_I) begin
         cmd_now = CMD_RD_BEGIN;
      end else if (selected && !CTRL_ADDR_STROBE_N_I) begin
         cmd_now = wr_cond ? CMD_WR_BEGIN : CMD_RD_BEGIN;
      end else if (!PROC_ADDR_STROBE_N_I && !CHIP_SEL_PRIMARY_N_I) begin
         // Primary select on, any other select off: float; primary off ignores this strobe
         cmd_now = CMD_DESEL;
      end else if (!BURST_ADVANCE_N_I) begin
         cmd_now = wr_cond ? CMD_WR_CONT : CMD_RD_CONT;
      end else begin
         cmd_now = wr_cond ? CMD_WR_HOLD : CMD_RD_HOLD;
      end
   end

   // Cycle class of the command
   always_comb begin
      case (cmd_now)
         CMD_RD_BEGIN, CMD_RD_CONT, CMD_RD_HOLD: begin
            is_read  = 1'b1;
            is_write = 1'b0;
         end
         CMD_WR_BEGIN, CMD_WR_CONT, CMD_WR_HOLD: begin
            is_read  = 1'b0;
            is_write = 1'b1;
         end
         default: begin
            is_read  = 1'b0;
            is_write = 1'b0;
         end
      endcase
   end

   // Burst counter control; dummy reads step it like any read
   assign bif.load       = (cmd_now == CMD_RD_BEGIN) || (cmd_now == CMD_WR_BEGIN);
   assign bif.advance    = (cmd_now == CMD_RD_CONT) || (cmd_now == CMD_WR_CONT);
   assign bif.start_lo   = ADDR_I[BURST_W-1:0];
   assign bif.interleave = BURST_ORDER_SEL_N_I;

   burst_counter u_burst (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .bus   (bif.cnt)
   );

   // Address and lane enables presented to the array
   assign hi_now   = bif.load ? ADDR_I[ADDR_W-1:BURST_W] : st_r.base_hi;
   assign mem_addr = {hi_now, bif.addr_lo};
   assign mem_we   = is_write ? lanes_wr : '0;

   lane_memory #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_mem (
      .clk_i     (MCLK_I),
      .addr_i    (mem_addr),
      .lane_we_i (mem_we),
      .wdata_i   (DQ_I),
      .rdata_o   (mem_rdata)
   );

   // Output source: flow-through takes array data, pipelined one stage later
   assign src_read = pipelined ? st_r.rd_s2 : st_r.rd_s1;
   assign src_data = pipelined ? st_r.pipe : mem_rdata;

   // Next state: pipeline of reads, drive control and data pins
   always_comb begin
      st_nxt          = st_r;
      st_nxt.standby  = sleeping;
      st_nxt.cmd      = cmd_now;
      st_nxt.base_hi  = hi_now;
      st_nxt.rd_s1    = is_read;
      st_nxt.rd_s2    = st_r.rd_s1;
      st_nxt.wr_s1    = is_write;
      st_nxt.desel_s1 = (cmd_now == CMD_DESEL) || sleeping;
      st_nxt.pipe     = mem_rdata;
      st_nxt.oe_n     = DRIVE_OFF_N;
      if (src_read) begin
         st_nxt.dq = src_data;
      end
      if (src_read && !OUT_EN_N_I) begin
         st_nxt.oe_n = 1'b0;
      end
      // Single mode cuts the pipelined read behind a deselect
      if (pipelined && single_desel && st_r.desel_s1) begin
         st_nxt.oe_n = DRIVE_OFF_N;
      end
      // Dual mode keeps the last flow-through read on the pins one more cycle
      if (!pipelined && !single_desel && st_r.desel_s1 && st_r.rd_s2 && !OUT_EN_N_I) begin
         st_nxt.oe_n = 1'b0;
      end
      // Writes and sleep never see the drivers on
      if (st_r.wr_s1 || is_write || sleeping || OUT_EN_N_I) begin
         st_nxt.oe_n = DRIVE_OFF_N;
      end
   end

   // State register, all inputs taken on the rising edge
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         st_r.base_hi  <= '0;
         st_r.cmd      <= CMD_NOP;
         st_r.rd_s1    <= RD_PIPE_RST;
         st_r.rd_s2    <= RD_PIPE_RST;
         st_r.wr_s1    <= RD_PIPE_RST;
         st_r.desel_s1 <= RD_PIPE_RST;
         st_r.pipe     <= '0;
         st_r.dq       <= '0;
         st_r.oe_n     <= DRIVE_OFF_N;
         st_r.standby  <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign DQ_O       = st_r.dq;
   assign DQ_OE_N_O  = st_r.oe_n;
   assign STANDBY_O  = st_r.standby;
   assign LAST_CMD_O = st_r.cmd;
endmodule : sync_burst_sram_control
`default_nettype wire

// ### ctrl_bus_model.sv
// Data wire model of the controller side sharing the DQ lines
`timescale 1ns/1ps
`default_nettype none
module ctrl_bus_model (
   // Clock
   input  wire logic        clk_i,
   // Device side
   input  wire logic [71:0] dev_d_i,
   input  wire logic        dev_oe_n_i,
   // Controller side
   input  wire logic [71:0] host_d_i,
   input  wire logic        host_en_i,
   // Resolved wire
   output logic      [71:0] bus_o
);
   logic [71:0] last_r = 72'h0;
   // Released wire shows the inverse of its last level
   always_comb begin
      if (!dev_oe_n_i) bus_o = dev_d_i;
      else if (host_en_i) bus_o = host_d_i;
      else bus_o = ~last_r;
   end
   // Last level seen on the wire
   always_ff @(posedge clk_i) last_r <= bus_o;
endmodule : ctrl_bus_model
`default_nettype wire

// ### sram_ctl_chk.sv
// Port-level assertions for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_chk #(
   parameter int LANES = 8
) (
   // Clock and reset
   input wire logic                MCLK_I,
   input wire logic                RST_I,
   // Controls
   input wire logic                SLEEP_REQ_I,
   input wire logic                CHIP_SEL_PRIMARY_N_I,
   input wire logic                CHIP_SEL_POS_I,
   input wire logic                CHIP_SEL_AUX_N_I,
   input wire logic                PROC_ADDR_STROBE_N_I,
   input wire logic                CTRL_ADDR_STROBE_N_I,
   input wire logic                BURST_ADVANCE_N_I,
   input wire logic                ALL_LANES_WRITE_N_I,
   input wire logic                LANE_WRITE_GATE_N_I,
   input wire logic [LANES-1:0]    LANE_WE_N_I,
   input wire logic                OUT_EN_N_I,
   // Outputs
   input wire logic                DQ_OE_N_O,
   input wire logic                STANDBY_O,
   input wire logic [2:0]          LAST_CMD_O
);
   import sram_ctl_pkg::*;
   logic sel, wr, run, idl;
   // Decoded select, write condition and strobe state
   assign sel = !CHIP_SEL_PRIMARY_N_I && CHIP_SEL_POS_I && !CHIP_SEL_AUX_N_I;
   assign wr  = !ALL_LANES_WRITE_N_I || (!LANE_WRITE_GATE_N_I && !(&LANE_WE_N_I));
   assign run = !SLEEP_REQ_I;
   // Primary select off makes the processor strobe a don't care
   assign idl = run && CTRL_ADDR_STROBE_N_I
                && (PROC_ADDR_STROBE_N_I || CHIP_SEL_PRIMARY_N_I);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   property p_wr_float; LAST_CMD_O inside {CMD_WR_BEGIN, CMD_WR_CONT, CMD_WR_HOLD}
      |-> DQ_OE_N_O ##1 DQ_OE_N_O; endproperty
   a_wr_float: assert property (p_wr_float) else $error("drive during write");
   property p_oe_off; OUT_EN_N_I |=> DQ_OE_N_O; endproperty
   a_oe_off: assert property (p_oe_off) else $error("drive with enable high");
   property p_sleep; SLEEP_REQ_I |=> STANDBY_O && DQ_OE_N_O && LAST_CMD_O == CMD_NOP; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not honoured");
   property p_desel; run && !sel && !CTRL_ADDR_STROBE_N_I |=> LAST_CMD_O == CMD_DESEL; endproperty
   a_desel: assert property (p_desel) else $error("deselect missed");
   property p_rd_beg; run && sel && !PROC_ADDR_STROBE_N_I |=> LAST_CMD_O == CMD_RD_BEGIN;
   endproperty
   a_rd_beg: assert property (p_rd_beg) else $error("read begin missed");
   property p_beg; run && sel && PROC_ADDR_STROBE_N_I && !CTRL_ADDR_STROBE_N_I
      |=> LAST_CMD_O == ($past(wr) ? CMD_WR_BEGIN : CMD_RD_BEGIN); endproperty
   a_beg: assert property (p_beg) else $error("begin burst wrong");
   property p_cont; idl && !BURST_ADVANCE_N_I
      |=> LAST_CMD_O == ($past(wr) ? CMD_WR_CONT : CMD_RD_CONT); endproperty
   a_cont: assert property (p_cont) else $error("continue wrong");
   property p_hold; idl && BURST_ADVANCE_N_I
      |=> LAST_CMD_O == ($past(wr) ? CMD_WR_HOLD : CMD_RD_HOLD); endproperty
   a_hold: assert property (p_hold) else $error("suspend wrong");
endmodule : sram_ctl_chk
bind sync_burst_sram_control sram_ctl_chk #(.LANES(LANES)) u_chk (.MCLK_I, .RST_I,
   .SLEEP_REQ_I, .CHIP_SEL_PRIMARY_N_I, .CHIP_SEL_POS_I, .CHIP_SEL_AUX_N_I,
   .PROC_ADDR_STROBE_N_I, .CTRL_ADDR_STROBE_N_I, .BURST_ADVANCE_N_I, .ALL_LANES_WRITE_N_I,
   .LANE_WRITE_GATE_N_I, .LANE_WE_N_I, .OUT_EN_N_I, .DQ_OE_N_O, .STANDBY_O, .LAST_CMD_O);
`default_nettype wire

// ### sync_burst_sram_control_tb_top.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_control_tb_top;
   import sram_ctl_pkg::*;
   logic        clk = 0, rst = 1, ord = 0, byp = 0, slp = 0, oe_n = 1;
   logic        ps_n = 1, cs_n = 1, adv_n = 1, gw_n = 1, bwg_n = 1, sdd = 1;
   logic [2:0]  s3 = 3'h2;
   logic [2:0]  sp [3] = '{3'h6, 3'h0, 3'h3};
   logic [7:0]  lwe_n = 8'hff;
   logic [17:0] addr = 18'h0;
   logic [71:0] dq = 72'h0, bus, dq_o;
   logic        dq_oe_n, stby;
   cmd_t        lcmd;
   int          mismatches = 0, checked = 0, lat = 0;
   // Clock of 40 ns
   always #20 clk = ~clk;
   // Device under test
   sync_burst_sram_control u_dut (
      .MCLK_I(clk), .RST_I(rst), .BURST_ORDER_SEL_N_I(ord), .OUTPUT_STAGE_BYPASS_N_I(byp),
      .DESELECT_DEPTH_SEL_I(sdd), .SLEEP_REQ_I(slp), .CHIP_SEL_PRIMARY_N_I(s3[2]),
      .CHIP_SEL_POS_I(s3[1]), .CHIP_SEL_AUX_N_I(s3[0]), .ADDR_I(addr),
      .PROC_ADDR_STROBE_N_I(ps_n), .CTRL_ADDR_STROBE_N_I(cs_n), .BURST_ADVANCE_N_I(adv_n),
      .ALL_LANES_WRITE_N_I(gw_n), .LANE_WRITE_GATE_N_I(bwg_n), .LANE_WE_N_I(lwe_n),
      .OUT_EN_N_I(oe_n), .DQ_I(bus), .DQ_O(dq_o), .DQ_OE_N_O(dq_oe_n), .STANDBY_O(stby),
      .LAST_CMD_O(lcmd));
   // Controller side of the data wire
   ctrl_bus_model u_bus (.clk_i(clk), .dev_d_i(dq_o), .dev_oe_n_i(dq_oe_n), .host_d_i(dq),
      .host_en_i(~gw_n | (~bwg_n & ~&lwe_n)), .bus_o(bus));
   // Compare and count
   task automatic chk(input string n, input logic [71:0] s, input logic [71:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // One bus cycle set at a rising edge
   task automatic drv(input logic p, c, v, g, input logic [17:0] a, input logic [71:0] d);
      @(posedge clk);
      {ps_n, cs_n, adv_n, gw_n, addr, dq} <= {p, c, v, g, a, d};
   endtask : drv
   // Both strobes idle, no advance
   task automatic idle();
      drv(1, 1, 1, 1, addr, dq);
   endtask : idle
   // Read begin, then check data and drive at the output cycle
   task automatic rd(input logic [17:0] a, input logic [71:0] e);
      drv(0, 1, 1, 1, a, dq);
      oe_n <= 0;
      idle();
      repeat (lat + 1) @(posedge clk);
      oe_n <= 1;
      #1 chk("rdata", dq_o, e);
      chk("drive_n", dq_oe_n, 72'h0);
   endtask : rd
   function automatic logic [71:0] mk(input int n);
      return {8{n[8:0]}};
   endfunction : mk
   task automatic done(input string n);
      $display("test %s done", n);
   endtask : done
   // Verdict and end of run
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   // Main sequence
   initial begin
      logic [17:0] b;
      repeat (4) @(posedge clk);
      rst <= 0;
      #1 chk("rst_drive_n", dq_oe_n, 72'h1);
      chk("rst_cmd", lcmd, CMD_NOP);
      chk("rst_standby", stby, 72'h0);
      chk("rst_data", dq_o, 72'h0);
      @(posedge clk);
      #1 chk("first_cmd", lcmd, CMD_RD_HOLD);
      chk("first_drive_n", dq_oe_n, 72'h1);
      done("reset");
      drv(1, 0, 1, 0, 18'h5, mk(3));
      idle();
      rd(18'h5, mk(3));
      done("single");
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         ord <= m[0];
         b = m ? 18'h21 : 18'h12;
         drv(1, 0, 1, 0, b, mk(10));
         for (int n = 1; n < 5; n++) drv(1, 1, 0, 0, b, mk(10 + n));
         idle();
         for (int n = 1; n < 4; n++)
            rd({b[17:2], m ? b[1:0] ^ 2'(n) : b[1:0] + 2'(n)}, mk(10 + n));
         rd(b, mk(14));
      end
      done("burst");
      drv(1, 0, 1, 0, 18'h30, mk(8));
      bwg_n <= 0;
      lwe_n <= 8'hed;
      drv(1, 0, 1, 1, 18'h30, {8{9'h1ff}});
      idle();
      lwe_n <= 8'hff;
      rd(18'h30, {{3{9'h8}}, 9'h1ff, {2{9'h8}}, 9'h1ff, 9'h8});
      @(posedge clk);
      bwg_n <= 1;
      done("lanes");
      drv(1, 0, 1, 0, 18'h40, mk(20));
      drv(1, 0, 1, 0, 18'h41, mk(21));
      @(posedge clk);
      oe_n <= 1;
      drv(0, 1, 1, 1, 18'h40, dq);
      drv(1, 1, 0, 1, 18'h40, dq);
      idle();
      oe_n <= 0;
      #1 chk("dummy_drive_n", dq_oe_n, 72'h1);
      @(posedge clk);
      #1 chk("dummy_step", dq_o, mk(21));
      rd(18'h40, mk(20));
      @(posedge clk);
      #1 chk("hold", dq_o, mk(20));
      done("dummy_hold");
      for (int k = 0; k < 3; k++) begin
         drv(1, 0, 1, 1, 18'h40, dq);
         s3 <= sp[k];
         oe_n <= 0;
         drv(1, 0, 1, 1, 18'h40, dq);
         @(posedge clk);
         #1 chk("desel_cmd", lcmd, CMD_DESEL);
         chk("desel_drive_n", dq_oe_n, 72'h1);
      end
      @(posedge clk);
      s3 <= 3'h2;
      oe_n <= 1;
      done("deselect");
      @(posedge clk);
      slp <= 1;
      drv(0, 1, 1, 1, 18'h5, dq);
      @(posedge clk);
      #1 chk("standby", stby, 72'h1);
      chk("sleep_cmd", lcmd, CMD_NOP);
      @(posedge clk);
      slp <= 0;
      done("sleep");
      // Read then deselect: dual mode drives one more cycle, single does not
      for (int d = 0; d < 2; d++) begin
         @(posedge clk);
         sdd <= d[0];
         oe_n <= 0;
         drv(0, 1, 1, 1, 18'h5, dq);
         drv(1, 0, 1, 1, 18'h5, dq);
         s3 <= 3'h6;
         idle();
         s3 <= 3'h2;
         @(posedge clk);
         oe_n <= 1;
         #1 chk("dcd_drive_n", dq_oe_n, 72'(d));
         chk("dcd_data", dq_o, mk(3));
         chk("awake", stby, 72'h0);
      end
      done("deselect_depth");
      @(posedge clk);
      byp <= 1;
      lat = 1;
      rd(18'h5, mk(3));
      done("pipelined");
      conclude();
   end
endmodule : sync_burst_sram_control_tb_top
`default_nettype wire
